// >>> render_debug_status_regs.sv
// Debug and status register set of the render command streamer
//
// Overview of operation
// RQ1: Read sync flushes chipset buffers, then returns zero
// RQ2: Ident bit 3 set for batch buffer faults
// RQ3: Ident bits 2:0 give ring, always zero
// RQ4: Non-zero snoop sync write starts cacheable flush
// RQ5: Error header reloads with every executed header
// RQ6: Done bits other than 20 and 19 set when engines idle; reset pattern
// RQ7: Done bit 1 parser done, bit 0 ring enable
// RQ8: Done bits 5 and 4 are arbiter rows
// RQ9: Done bits 20 and 19 read zero
// RQ10: Head pointer in 31:2, low bits zero
// RQ11: Fetch offset holds 30-bit qword offset
// RQ12: Extra done vector per variant, resets zero
// RQ13: Host write to flush control flushes write buffer
// RQ14: Command stream flush control write ignored, completes
// RQ15: Software never reads flush control location
// RQ16: Software flushes after translation table changes
// RQ17: Preemption debug not context saved; 31:5 zero
// RQ18: Writes to read-only status registers ignored
`timescale 1ns/1ps
`include "render_debug_status_params.svh"

module render_debug_status_regs
    import render_debug_status_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter bit NEWER_VARIANT = 1'b1
) (
    input wire logic ref_clk, // Core clock, 10 MHz
    input wire logic rstn, // Async reset, active low
    input wire logic reg_rd, // Register read strobe
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_wr_cmd, // Write comes from command stream
    input wire logic [ADDR_W-1:0] reg_addr, // Byte address
    input wire logic [31:0] reg_wdata, // Write data
    output logic [31:0] reg_rdata, // Read data
    output logic reg_ack, // Access complete
    input wire logic instr_exec, // Instruction header executed
    input wire logic [31:0] instr_header, // Dword 0 of that instruction
    input wire logic instr_from_batch, // Instruction came from batch
    input wire logic parse_error, // Invalid instruction detected
    input wire logic [31:0] parse_state_in, // Live parser state
    input wire logic [31:0] unit_done_in, // Live done signals
    input wire logic [31:0] extra_done_in, // Live extra done signals
    input wire logic [29:0] head_dword_addr, // Active head dword address
    input wire logic [29:0] fetch_qword_off, // Primary fetch offset
    output logic chip_flush_req, // Chipset buffer flush request
    input wire logic chip_flush_done, // Chipset buffer flush done
    output logic snoop_flush_req, // Cacheable write flush request
    input wire logic snoop_flush_done, // Cacheable flush done
    output logic wb_flush_pulse, // Write buffer flush pulse
    output logic [4:0] preempt_ctl // Preemption debug controls
);
    initial begin
        if (ADDR_W < 14 || ADDR_W > 32) begin
            $error("ADDR_W must lie in 14..32");
        end
    end

    typedef struct packed {
        sync_state_e rd_sync;
        sync_state_e snoop_sync;
        logic [31:0] ident;
        logic [31:0] header;
        logic [31:0] done;
        logic [31:0] pstate;
        logic [31:0] head;
        logic [31:0] fetch;
        logic [31:0] extra;
        logic [4:0] preempt;
        logic [31:0] rdata;
        logic ack;
        logic chip_req;
        logic snoop_req;
        logic wb_pulse;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    logic [15:0] a16;
    assign a16 = 16'(reg_addr);

    // Next-state logic of all registers and the bus answer
    always_comb begin
        nxt_st = st_ff;
        nxt_st.wb_pulse = 1'b0;
        nxt_st.ack = 1'b0;
        nxt_st.rdata = 32'h0;
        // Live status captured every cycle; bus writes never touch it
        nxt_st.done = unit_done_in & `UNIT_DONE_IMPL_MASK; // RQ6 RQ7 RQ8 RQ9
        nxt_st.pstate = parse_state_in;
        nxt_st.head = {head_dword_addr, 2'b00}; // RQ10
        nxt_st.fetch = {2'b00, fetch_qword_off}; // RQ11
        nxt_st.extra = NEWER_VARIANT ? extra_done_in
                                     : {12'h000, extra_done_in[19:0]}; // RQ12
        if (instr_exec) begin
            nxt_st.header = instr_header; // RQ5
        end
        if (parse_error) begin
            nxt_st.ident = 32'h0;
            nxt_st.ident[`BIT_BATCH_ERR] = instr_from_batch; // RQ2
            nxt_st.ident[2:0] = `RING_ID_ZERO; // RQ3
        end
        // Chipset flush ends when the memory side reports done
        if (st_ff.rd_sync == SYNC_BUSY && chip_flush_done) begin
            nxt_st.rd_sync = SYNC_IDLE;
            nxt_st.chip_req = 1'b0;
            nxt_st.ack = 1'b1; // RQ1
            nxt_st.rdata = 32'h0;
        end
        if (st_ff.snoop_sync == SYNC_BUSY && snoop_flush_done) begin
            nxt_st.snoop_sync = SYNC_IDLE;
            nxt_st.snoop_req = 1'b0;
        end
        // Bus decode
        if (reg_rd && st_ff.rd_sync == SYNC_IDLE && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            case (a16)
                `OFF_MEMORY_READ_SYNC: begin
                    // Read held until chipset buffers drain
                    nxt_st.ack = 1'b0;
                    nxt_st.rd_sync = SYNC_BUSY; // RQ1
                    nxt_st.chip_req = 1'b1;
                end
                `OFF_PARSER_ERROR_IDENT: begin
                    if (NEWER_VARIANT && st_ff.snoop_sync == SYNC_BUSY) begin
                        nxt_st.ack = 1'b0; // RQ4
                    end else begin
                        nxt_st.rdata = NEWER_VARIANT ? 32'h0 : st_ff.ident;
                    end
                end
                `OFF_PARSER_ERROR_HEADER: nxt_st.rdata = st_ff.header;
                `OFF_UNIT_DONE_STATUS: nxt_st.rdata = st_ff.done;
                `OFF_PARSER_STATE: nxt_st.rdata = st_ff.pstate;
                `OFF_ACTIVE_HEAD_POINTER: nxt_st.rdata = st_ff.head;
                `OFF_PRIMARY_FETCH_OFFSET: nxt_st.rdata = st_ff.fetch;
                `OFF_EXTRA_UNIT_DONE: nxt_st.rdata = st_ff.extra;
                `OFF_PREEMPTION_DEBUG: nxt_st.rdata = {27'h0, st_ff.preempt};
                default: nxt_st.rdata = 32'h0;
            endcase
        end else if (reg_wr && !st_ff.ack) begin
            nxt_st.ack = 1'b1; // RQ14
            case (a16)
                `OFF_PARSER_ERROR_IDENT: begin
                    if (NEWER_VARIANT && reg_wdata != 32'h0
                        && !reg_wr_cmd) begin
                        nxt_st.snoop_sync = SYNC_BUSY; // RQ4
                        nxt_st.snoop_req = 1'b1;
                    end
                end
                `OFF_FLUSH_CONTROL_LO, `OFF_FLUSH_CONTROL_HI: begin
                    nxt_st.wb_pulse = !reg_wr_cmd; // RQ13 RQ14
                end
                `OFF_PREEMPTION_DEBUG: begin
                    nxt_st.preempt = 5'(reg_wdata & `PREEMPT_DBG_MASK); // RQ17
                end
                default: ; // RQ18
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{rd_sync: SYNC_IDLE, snoop_sync: SYNC_IDLE,
                       done: `RST_UNIT_DONE, default: '0}; // RQ6
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = st_ff.rdata;
    assign reg_ack = st_ff.ack;
    assign chip_flush_req = st_ff.chip_req;
    assign snoop_flush_req = st_ff.snoop_req;
    assign wb_flush_pulse = st_ff.wb_pulse;
    assign preempt_ctl = st_ff.preempt;

    // Checks
    a_done_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_ff.done[20:19] == 2'b00) else $error("done reserved set"); // RQ9
    a_head_low_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_ff.head[1:0] == 2'b00) else $error("head low bits set"); // RQ10
    a_fetch_track: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> st_ff.fetch == {2'b00, $past(fetch_qword_off)})
        else $error("fetch offset stale"); // RQ11
    a_header_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        instr_exec |=> st_ff.header == $past(instr_header))
        else $error("header not loaded"); // RQ5
    a_ident_batch: assert property (@(posedge ref_clk) disable iff (!rstn)
        parse_error |=> st_ff.ident[3] == $past(instr_from_batch)
        && st_ff.ident[2:0] == 3'h0) else $error("ident wrong"); // RQ2 RQ3
    a_rdsync_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_ff.rd_sync == SYNC_BUSY && chip_flush_done
        |=> reg_ack && reg_rdata == 32'h0) else $error("sync read"); // RQ1
    a_cmd_flush_none: assert property (@(posedge ref_clk) disable iff (!rstn)
        reg_wr && reg_wr_cmd |=> !wb_flush_pulse)
        else $error("cmd write flushed"); // RQ14
    a_host_flush: assert property (@(posedge ref_clk) disable iff (!rstn)
        reg_wr && !reg_wr_cmd && !st_ff.ack && !reg_rd
        && a16 == `OFF_FLUSH_CONTROL_LO |=> wb_flush_pulse)
        else $error("host flush missing"); // RQ13
    a_preempt_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
        reg_ack && $past(reg_rd) && $past(a16) == `OFF_PREEMPTION_DEBUG
        |-> reg_rdata[31:5] == 27'h0) else $error("preempt high"); // RQ17
    c_flush: cover property (@(posedge ref_clk) wb_flush_pulse);
    c_rd_sync: cover property (@(posedge ref_clk)
        chip_flush_req ##[1:20] !chip_flush_req);
    c_snoop: cover property (@(posedge ref_clk)
        snoop_flush_req ##[1:20] !snoop_flush_req);
    c_error: cover property (@(posedge ref_clk) parse_error && instr_from_batch);
endmodule

// >>> render_debug_status_params.svh
// Offsets, reset values and field positions of the debug status registers
`ifndef RENDER_DEBUG_STATUS_PARAMS_SVH
`define RENDER_DEBUG_STATUS_PARAMS_SVH
`define OFF_MEMORY_READ_SYNC 16'h2060
`define OFF_PARSER_ERROR_IDENT 16'h2064
`define OFF_PARSER_ERROR_HEADER 16'h2068
`define OFF_UNIT_DONE_STATUS 16'h206C
`define OFF_PARSER_STATE 16'h2070
`define OFF_ACTIVE_HEAD_POINTER 16'h2074
`define OFF_PRIMARY_FETCH_OFFSET 16'h2078
`define OFF_EXTRA_UNIT_DONE 16'h207C
`define OFF_FLUSH_CONTROL_LO 16'h2170
`define OFF_FLUSH_CONTROL_HI 16'h2174
`define OFF_PREEMPTION_DEBUG 16'h2718
`define RST_UNIT_DONE 32'hFFE7FFFE
`define UNIT_DONE_IMPL_MASK 32'hFFE7FFFF
`define BIT_BATCH_ERR 3
`define BIT_PARSER_DONE 1
`define BIT_RING0_EN 0
`define BIT_ARB_ROW0 5
`define BIT_ARB_ROW1 4
`define PREEMPT_DBG_MASK 32'h0000001F
`define RING_ID_ZERO 3'h0
`endif

// >>> render_debug_status_pkg.sv
// Types shared by the debug status register block
package render_debug_status_pkg;
    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b00,
        SYNC_BUSY = 2'b01
    } sync_state_e;
endpackage

// >>> tb.sv
// Self-checking bench for the debug and status register block
`timescale 1ns/1ps
`include "render_debug_status_params.svh"

module tb;
    logic ref_clk = 0, rstn = 0, reg_rd = 0, reg_wr = 0, reg_wr_cmd = 0;
    logic [15:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, instr_header = '0, got;
    logic instr_exec = 0, instr_from_batch = 0, parse_error = 0, reg_ack;
    logic [31:0] parse_state_in = '0, unit_done_in = '0, extra_done_in = '0;
    logic [29:0] head_dword_addr = '0, fetch_qword_off = '0;
    logic chip_flush_req, chip_flush_done = 0, snoop_flush_req;
    logic snoop_flush_done = 0, wb_flush_pulse, pulse;
    logic chip_seen = 0, snoop_seen = 0;
    logic [4:0] preempt_ctl;
    int num_errors = 0, comparisons = 0;

    render_debug_status_regs DUT (.ref_clk, .rstn, .reg_rd, .reg_wr,
        .reg_wr_cmd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
        .instr_exec, .instr_header, .instr_from_batch, .parse_error,
        .parse_state_in, .unit_done_in, .extra_done_in, .head_dword_addr,
        .fetch_qword_off, .chip_flush_req, .chip_flush_done,
        .snoop_flush_req, .snoop_flush_done, .wb_flush_pulse, .preempt_ctl);

    // Clock, 100 ns period
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // Flush partners answer 10 ns after the clock edge at which each request is seen
    always @(posedge ref_clk) begin
        #10;
        chip_flush_done = chip_flush_req;
        snoop_flush_done = snoop_flush_req;
        if (chip_flush_req === 1'b1) chip_seen = 1;
        if (snoop_flush_req === 1'b1) snoop_seen = 1;
    end

    task automatic close_out();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask

    // One access: hold strobe until ack, capture data, drop, idle a cycle
    task automatic acc(input logic w, cmd, input logic [15:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        reg_rd = !w;
        reg_wr = w;
        reg_wr_cmd = cmd;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk); #10;
        while (reg_ack !== 1'b1) begin
            n++;
            if (n > 40) begin
                $display("[ERR] ack_wait exp 1 got 0");
                num_errors++;
                close_out();
            end
            @(posedge ref_clk); #10;
        end
        got = reg_rdata;
        pulse = wb_flush_pulse;
        reg_rd = 0;
        reg_wr = 0;
        reg_wr_cmd = 0;
        @(posedge ref_clk); #10;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [31:0] e);
        acc(0, 0, a, 0);
        chk($sformatf("read_%h", a), e, got);
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        chk("done_reset", `RST_UNIT_DONE, DUT.st_ff.done);
        #10 rstn = 1;
        rdc(`OFF_PREEMPTION_DEBUG, 32'h0);
        unit_done_in = 32'hFFFFFFFF;
        head_dword_addr = 30'h2AAAAAAB;
        fetch_qword_off = 30'h15555554;
        extra_done_in = 32'hA5C3_0F96;
        parse_state_in = 32'h1234_5678;
        repeat (3) @(posedge ref_clk);
        #10;
        rdc(`OFF_UNIT_DONE_STATUS, 32'hFFE7FFFF);
        unit_done_in = 32'h0018_0032;
        repeat (3) @(posedge ref_clk);
        #10;
        rdc(`OFF_UNIT_DONE_STATUS, 32'h0000_0032);
        acc(1, 0, `OFF_UNIT_DONE_STATUS, 32'hFFFFFFFF);
        rdc(`OFF_UNIT_DONE_STATUS, 32'h0000_0032);
        rdc(`OFF_ACTIVE_HEAD_POINTER, 32'hAAAAAAAC);
        rdc(`OFF_PRIMARY_FETCH_OFFSET, 32'h15555554);
        rdc(`OFF_EXTRA_UNIT_DONE, 32'hA5C3_0F96);
        rdc(`OFF_PARSER_STATE, 32'h1234_5678);
        rdc(16'h2000, 32'h0);
        rdc(`OFF_MEMORY_READ_SYNC, 32'h0);
        chk("chip_flush_seen", 1, {31'h0, chip_seen});
        // Two headers back to back; the later one must stay
        instr_from_batch = 1;
        instr_header = 32'hDEAD_0001;
        instr_exec = 1;
        @(posedge ref_clk); #10;
        instr_header = 32'hBEEF_0002;
        parse_error = 1;
        @(posedge ref_clk); #10;
        instr_exec = 0;
        parse_error = 0;
        repeat (2) @(posedge ref_clk);
        #10;
        rdc(`OFF_PARSER_ERROR_HEADER, 32'hBEEF_0002);
        acc(1, 0, `OFF_PARSER_ERROR_HEADER, 32'h0);
        rdc(`OFF_PARSER_ERROR_HEADER, 32'hBEEF_0002);
        // Snoop sync: zero and command-stream writes start nothing
        acc(1, 0, `OFF_PARSER_ERROR_IDENT, 32'h0);
        acc(1, 1, `OFF_PARSER_ERROR_IDENT, 32'h1);
        chk("snoop_idle", 0, {31'h0, snoop_seen});
        acc(1, 0, `OFF_PARSER_ERROR_IDENT, 32'h8000_0000);
        repeat (3) @(posedge ref_clk);
        #10;
        chk("snoop_seen", 1, {31'h0, snoop_seen});
        rdc(`OFF_PARSER_ERROR_IDENT, 32'h0);
        // Flush control: host dwords pulse, command stream does not
        // Flush after table changes; the location is never read
        acc(1, 0, `OFF_FLUSH_CONTROL_LO, 32'h1234);
        chk("flush_lo", 1, {31'h0, pulse});
        acc(1, 0, `OFF_FLUSH_CONTROL_HI, 32'h0);
        chk("flush_hi", 1, {31'h0, pulse});
        acc(1, 1, `OFF_FLUSH_CONTROL_LO, 32'hFFFF);
        chk("flush_cmd", 0, {31'h0, pulse});
        acc(1, 0, `OFF_PREEMPTION_DEBUG, 32'hFFFFFFFF);
        rdc(`OFF_PREEMPTION_DEBUG, 32'h0000_001F);
        chk("preempt_ctl", 32'h1F, {27'h0, preempt_ctl});
        close_out();
    end
endmodule
